// [hw/pcg_top.v]
// Peripheral clock gating: six gating registers behind an AXI4-Lite
// slave, per-unit clock enables, bus-fault answers for gated units
// and a fault interrupt. Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
`include "pcg_defines.vh"

module pcg_top #(
  parameter ADDR_W = 12                   // Register address width
) (
  input  wire              aclk,          // Clock, 100 MHz
  input  wire              aresetn,       // Synchronous reset, low
  input  wire [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire              s_axi_awvalid, // Write address valid
  output reg               s_axi_awready, // Write address ready
  input  wire [31:0]       s_axi_wdata,   // Write data
  input  wire [3:0]        s_axi_wstrb,   // Write byte strobes
  input  wire              s_axi_wvalid,  // Write data valid
  output reg               s_axi_wready,  // Write data ready
  output reg  [1:0]        s_axi_bresp,   // Write response
  output reg               s_axi_bvalid,  // Write response valid
  input  wire              s_axi_bready,  // Write response ready
  input  wire [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire              s_axi_arvalid, // Read address valid
  output reg               s_axi_arready, // Read address ready
  output reg  [31:0]       s_axi_rdata,   // Read data
  output reg  [1:0]        s_axi_rresp,   // Read response
  output reg               s_axi_rvalid,  // Read data valid
  input  wire              s_axi_rready,  // Read data ready
  input  wire              sleep_req,     // Processor in sleep
  input  wire              deep_sleep_req,// Processor in deep sleep
  input  wire [10:0]       periph_req,    // Access strobe per unit
  output reg  [10:0]       unit_clk_en,   // Clock enable per unit
  output reg  [10:0]       periph_done,   // Normal completion pulse
  output reg  [10:0]       periph_fault,  // Bus fault pulse
  output reg               irq            // Fault interrupt, level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [3:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `PCG_OFF_RUN0:    reg_index = `PCG_IDX_RUN0;
        `PCG_OFF_RUN1:    reg_index = `PCG_IDX_RUN1;
        `PCG_OFF_SLP0:    reg_index = `PCG_IDX_SLP0;
        `PCG_OFF_SLP1:    reg_index = `PCG_IDX_SLP1;
        `PCG_OFF_DSL0:    reg_index = `PCG_IDX_DSL0;
        `PCG_OFF_DSL1:    reg_index = `PCG_IDX_DSL1;
        `PCG_OFF_RCC:     reg_index = `PCG_IDX_RCC;
        `PCG_OFF_STATE:   reg_index = `PCG_IDX_STATE;
        `PCG_OFF_INT_STS: reg_index = `PCG_IDX_INT_STS;
        `PCG_OFF_INT_MSK: reg_index = `PCG_IDX_INT_MSK;
        default:          reg_index = `PCG_IDX_NONE;
      endcase
    end
  endfunction

  // Merge strobed bytes, then drop every reserved bit
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    input [31:0] mask;
    integer i;
    reg [31:0] tmp;
    begin
      tmp = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          tmp[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
      merge = tmp & mask;
    end
  endfunction

  // Unmapped words answer with an error and change nothing
  function [1:0] resp_code;
    input [3:0] idx;
    begin
      if (idx == `PCG_IDX_NONE) begin
        resp_code = `PCG_RESP_SLVERR;
      end else begin
        resp_code = `PCG_RESP_OKAY;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0]       run0_q;
  reg [31:0]       run1_q;
  reg [31:0]       slp0_q;
  reg [31:0]       slp1_q;
  reg [31:0]       dsl0_q;
  reg [31:0]       dsl1_q;
  reg [31:0]       rcc_q;
  reg [10:0]       int_sts_q;
  reg [10:0]       int_msk_q;
  reg              aw_have_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg              w_have_q;
  reg [31:0]       w_data_q;
  reg [3:0]        w_strb_q;

  wire             aw_hs;
  wire             w_hs;
  wire             ar_hs;
  wire             do_wr;
  wire [3:0]       wr_idx;
  wire [3:0]       rd_idx;
  wire [10:0]      unit_en_d;
  wire [10:0]      fault_ev;
  wire [31:0]      clr_word;
  wire [10:0]      sts_clr;
  wire [10:0]      int_sts_d;
  wire             aw_have_d;
  wire             w_have_d;
  reg  [31:0]      rd_word;
  wire [31:0]      msk_word;
  wire [31:0]      state_word;
  wire             irq_d;

  assign aw_hs  = s_axi_awvalid & s_axi_awready;
  assign w_hs   = s_axi_wvalid & s_axi_wready;
  assign ar_hs  = s_axi_arvalid & s_axi_arready;
  // Address and data may arrive in either order
  assign do_wr  = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr_q);
  assign rd_idx = reg_index(s_axi_araddr);

  assign aw_have_d = (aw_have_q | aw_hs) & ~do_wr;
  assign w_have_d  = (w_have_q | w_hs) & ~do_wr;

  // ----------------------------------------------------------------
  // Effective enable selection
  // ----------------------------------------------------------------
  pcg_gate_sel u_sel (
    .run0      (run0_q),
    .run1      (run1_q),
    .slp0      (slp0_q),
    .slp1      (slp1_q),
    .dsl0      (dsl0_q),
    .dsl1      (dsl1_q),
    .auto_gating_select       (rcc_q[`PCG_RCC_ACG_BIT]),
    .sleep_req (sleep_req),
    .deep_req  (deep_sleep_req),
    .unit_en   (unit_en_d)
  );

  // ----------------------------------------------------------------
  // Fault events and sticky status
  // ----------------------------------------------------------------
  // Judged against the enable the units actually see this cycle
  assign fault_ev = periph_req & ~unit_clk_en;

  assign clr_word = merge(32'h0000_0000, w_data_q, w_strb_q,
                          32'hFFFF_FFFF);
  assign sts_clr  = (do_wr && wr_idx == `PCG_IDX_INT_STS) ?
                    clr_word[10:0] : 11'h000;
  // A fault in the clearing cycle stays set
  assign int_sts_d = (int_sts_q & ~sts_clr) | fault_ev;
  // Registered below so the pin stays glitch-free; one edge behind
  assign irq_d     = |(int_sts_q & int_msk_q);
  // Mask takes only the unit bits; the rest read zero
  assign msk_word  = merge({21'h000000, int_msk_q}, w_data_q, w_strb_q,
                           `PCG_INT_MASK);
  // Live view: software sees the enables the units see
  assign state_word = {14'h0000, deep_sleep_req, sleep_req, 5'h00,
                       unit_clk_en};

  // ----------------------------------------------------------------
  // Unit-side outputs
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      unit_clk_en  <= `PCG_UNIT_RESET;
      periph_done  <= 11'h000;
      periph_fault <= 11'h000;
    end else begin
      unit_clk_en  <= unit_en_d;
      periph_done  <= periph_req & unit_clk_en;
      periph_fault <= fault_ev;
    end
  end

  // ----------------------------------------------------------------
  // Fault status and interrupt
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      int_sts_q <= 11'h000;
      irq       <= 1'b0;
    end else begin
      int_sts_q <= int_sts_d;
      irq       <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= {ADDR_W{1'b0}};
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCG_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      s_axi_awready <= ~aw_have_d;
      s_axi_wready  <= ~w_have_d;
      // A held word waits until the previous response has drained
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= resp_code(wr_idx);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      run0_q    <= `PCG_GATE_RESET;
      run1_q    <= `PCG_GATE_RESET;
      slp0_q    <= `PCG_GATE_RESET;
      slp1_q    <= `PCG_GATE_RESET;
      dsl0_q    <= `PCG_GATE_RESET;
      dsl1_q    <= `PCG_GATE_RESET;
      rcc_q     <= 32'h0000_0000;
      int_msk_q <= 11'h000;
    end else if (do_wr) begin
      case (wr_idx)
        `PCG_IDX_RUN0: begin
          run0_q <= merge(run0_q, w_data_q, w_strb_q, `PCG_G0_MASK);
        end
        `PCG_IDX_RUN1: begin
          run1_q <= merge(run1_q, w_data_q, w_strb_q, `PCG_G1_MASK);
        end
        `PCG_IDX_SLP0: begin
          slp0_q <= merge(slp0_q, w_data_q, w_strb_q, `PCG_G0_MASK);
        end
        `PCG_IDX_SLP1: begin
          slp1_q <= merge(slp1_q, w_data_q, w_strb_q, `PCG_G1_MASK);
        end
        `PCG_IDX_DSL0: begin
          dsl0_q <= merge(dsl0_q, w_data_q, w_strb_q, `PCG_G0_MASK);
        end
        `PCG_IDX_DSL1: begin
          dsl1_q <= merge(dsl1_q, w_data_q, w_strb_q, `PCG_G1_MASK);
        end
        `PCG_IDX_RCC: begin
          rcc_q <= merge(rcc_q, w_data_q, w_strb_q, `PCG_RCC_MASK);
        end
        `PCG_IDX_INT_MSK: begin
          int_msk_q <= msk_word[10:0];
        end
        default: begin
          // Status is write-one-to-clear; state word is read-only
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @* begin
    case (rd_idx)
      `PCG_IDX_RUN0:    rd_word = run0_q;
      `PCG_IDX_RUN1:    rd_word = run1_q;
      `PCG_IDX_SLP0:    rd_word = slp0_q;
      `PCG_IDX_SLP1:    rd_word = slp1_q;
      `PCG_IDX_DSL0:    rd_word = dsl0_q;
      `PCG_IDX_DSL1:    rd_word = dsl1_q;
      `PCG_IDX_RCC:     rd_word = rcc_q;
      `PCG_IDX_STATE:   rd_word = state_word;
      `PCG_IDX_INT_STS: rd_word = {21'h000000, int_sts_q};
      `PCG_IDX_INT_MSK: rd_word = {21'h000000, int_msk_q};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PCG_RESP_OKAY;
    end else begin
      // Data captured with the address, so it stands until taken
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= resp_code(rd_idx);
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [hw/pcg_defines.vh]
// Constants for the peripheral clock gating block: offsets, fields,
// reset values and bus codes. Included by every design file.
`ifndef PCG_DEFINES_VH
`define PCG_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG_OFF_RUN0      12'h100
`define PCG_OFF_RUN1      12'h104
`define PCG_OFF_SLP0      12'h110
`define PCG_OFF_SLP1      12'h114
`define PCG_OFF_DSL0      12'h120
`define PCG_OFF_DSL1      12'h124
`define PCG_OFF_RCC       12'h130
`define PCG_OFF_STATE     12'h134
`define PCG_OFF_INT_STS   12'h140
`define PCG_OFF_INT_MSK   12'h144

// ----------------------------------------------------------------
// Decoded register indices
// ----------------------------------------------------------------
`define PCG_IDX_RUN0      4'h0
`define PCG_IDX_RUN1      4'h1
`define PCG_IDX_SLP0      4'h2
`define PCG_IDX_SLP1      4'h3
`define PCG_IDX_DSL0      4'h4
`define PCG_IDX_DSL1      4'h5
`define PCG_IDX_RCC       4'h6
`define PCG_IDX_STATE     4'h7
`define PCG_IDX_INT_STS   4'h8
`define PCG_IDX_INT_MSK   4'h9
`define PCG_IDX_NONE      4'hF

// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define PCG_G0_MASK       32'h0100_0048
`define PCG_G1_MASK       32'h000F_1013
`define PCG_RCC_MASK      32'h0000_0001
`define PCG_INT_MASK      32'h0000_07FF
`define PCG_GATE_RESET    32'h0000_0000
`define PCG_UNIT_RESET    11'h000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCG_G0_CAN_BIT    24
`define PCG_G0_HIB_BIT    6
`define PCG_G0_WDT_BIT    3
`define PCG_G1_TMR_LSB    16
`define PCG_G1_TMR_MSB    19
`define PCG_G1_I2C_BIT    12
`define PCG_G1_SSI_BIT    4
`define PCG_G1_ASYNC_SERIAL_GATE_1_BIT  1
`define PCG_G1_ASYNC_SERIAL_GATE_0_BIT  0
`define PCG_RCC_ACG_BIT   0
`define PCG_STATE_SLP_BIT 16
`define PCG_STATE_DSL_BIT 17
`define PCG_NUM_UNITS     11

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define PCG_RESP_OKAY     2'h0
`define PCG_RESP_SLVERR   2'h2

`endif

// [hw/pcg_gate_sel.v]
// Chooses the gating register set that applies in the current power
// state and maps its bits onto one enable per peripheral unit.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/100ps
`include "pcg_defines.vh"

module pcg_gate_sel (
  input  wire [31:0] run0,        // Run gating, group 0
  input  wire [31:0] run1,        // Run gating, group 1
  input  wire [31:0] slp0,        // Sleep gating, group 0
  input  wire [31:0] slp1,        // Sleep gating, group 1
  input  wire [31:0] dsl0,        // Deep-sleep gating, group 0
  input  wire [31:0] dsl1,        // Deep-sleep gating, group 1
  input  wire        auto_gating_select,         // Automatic gating selected
  input  wire        sleep_req,   // Processor in sleep
  input  wire        deep_req,    // Processor in deep sleep
  output reg  [10:0] unit_en      // Effective enable per unit
);

  // ----------------------------------------------------------------
  // Unit order: async_serial_gate_0, async_serial_gate_1, ssi, i2c, gp_timer_gate_0..3, wdt, hib, can
  // ----------------------------------------------------------------
  function [10:0] unit_map;
    input [31:0] g0;
    input [31:0] g1;
    begin
      unit_map = {g0[`PCG_G0_CAN_BIT], g0[`PCG_G0_HIB_BIT],
                  g0[`PCG_G0_WDT_BIT],
                  g1[`PCG_G1_TMR_MSB:`PCG_G1_TMR_LSB],
                  g1[`PCG_G1_I2C_BIT], g1[`PCG_G1_SSI_BIT],
                  g1[`PCG_G1_ASYNC_SERIAL_GATE_1_BIT], g1[`PCG_G1_ASYNC_SERIAL_GATE_0_BIT]};
    end
  endfunction

  // Deep sleep outranks sleep when both are requested
  always @* begin
    if (auto_gating_select && deep_req) begin
      unit_en = unit_map(dsl0, dsl1);
    end else if (auto_gating_select && sleep_req) begin
      unit_en = unit_map(slp0, slp1);
    end else begin
      unit_en = unit_map(run0, run1);
    end
  end

endmodule

// [sim/pcg_top_asserts.sv]
// Port-level assertions for the peripheral clock gating block.
// Bound onto pcg_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module pcg_top_asserts #(
  parameter ADDR_W = 12             // Register address width
) (
  input wire        aclk,           // Clock
  input wire        aresetn,        // Reset, low
  input wire        s_axi_awvalid,  // Write address valid
  input wire        s_axi_awready,  // Write address ready
  input wire        s_axi_bvalid,   // Write response valid
  input wire        s_axi_arvalid,  // Read address valid
  input wire        s_axi_arready,  // Read address ready
  input wire        s_axi_rvalid,   // Read data valid
  input wire        sleep_req,      // Sleep state
  input wire        deep_sleep_req, // Deep-sleep state
  input wire [10:0] periph_req,     // Unit access strobes
  input wire [10:0] unit_clk_en,    // Unit clock enables
  input wire [10:0] periph_done,    // Completion pulses
  input wire [10:0] periph_fault,   // Fault pulses
  input wire        irq             // Interrupt
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESET_OFF: assert property (
    $rose(aresetn) |-> unit_clk_en == 11'h000)
    else $error("unit enables not clear after reset");
  AST_FAULT_GATED: assert property (
    |periph_req |=> periph_fault == ($past(periph_req) & ~$past(unit_clk_en)))
    else $error("fault pulses differ from gated requests");
  AST_DONE_CLOCKED: assert property (
    |periph_req |=> periph_done == ($past(periph_req) & $past(unit_clk_en)))
    else $error("done pulses differ from clocked requests");
  // Register writes may reach the enables with the response or one edge after it
  AST_EN_CAUSE: assert property (
    $changed(unit_clk_en) && $past(aresetn) |->
      s_axi_bvalid || $past(s_axi_bvalid) ||
      $past(sleep_req) != $past(sleep_req, 2) ||
      $past(deep_sleep_req) != $past(deep_sleep_req, 2))
    else $error("unit enables changed without cause");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(|periph_fault) || s_axi_bvalid ||
      $past(s_axi_bvalid))
    else $error("interrupt rose without fault or write");
  AST_IRQ_FALL: assert property (
    $fell(irq) && $past(aresetn) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt fell without a write");
  AST_READ_NEXT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  AST_WRITE_RESP: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("write response missing");

  cover property (|periph_fault);
  cover property (|periph_done);
  cover property ($rose(irq));
endmodule

bind pcg_top pcg_top_asserts #(.ADDR_W(ADDR_W)) pcg_top_asserts_i (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
  .periph_req(periph_req), .unit_clk_en(unit_clk_en),
  .periph_done(periph_done), .periph_fault(periph_fault), .irq(irq)
);

// [sim/pcg_top_bench.sv]
// Self-checking bench for the peripheral clock gating block.
// Drives the AXI4-Lite slave, power state and unit strobes itself.
`timescale 1ns/100ps
`include "pcg_defines.vh"

module pcg_top_bench;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        slp, dsl, irq, auto_gating_select;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, r, msk;
  logic [1:0]  bresp, rresp;
  logic [10:0] preq, en, done, fault;
  logic [3:0]  strb;
  logic [33:0] exp_q[$];
  logic [31:0] g[6];
  logic [11:0] offs[6];
  int          mismatches, checks;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  pcg_top pcg_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_req(slp), .deep_sleep_req(dsl),
    .periph_req(preq), .unit_clk_en(en), .periph_done(done),
    .periph_fault(fault), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [10:0] unit_map(input logic [31:0] a, b);
    return {a[24], a[6], a[3], b[19:16], b[12], b[4], b[1:0]};
  endfunction

  function automatic logic [10:0] exp_en();
    if (auto_gating_select && dsl) return unit_map(g[4], g[5]);
    if (auto_gating_select && slp) return unit_map(g[2], g[3]);
    return unit_map(g[0], g[1]);
  endfunction

  task automatic chk(input string nm, input logic [33:0] seen, ex);
    checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("BAD handshake exp answer seen none");
    end_sim();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
    int n;
    exp_q.push_back({32'h0, rs});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    int n;
    exp_q.push_back({d, `PCG_RESP_OKAY});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) hang();
  endtask

  task automatic acc(input logic [10:0] q);
    exp_q.push_back({12'h0, q & ~exp_en(), q & exp_en()});
    @(posedge aclk);
    preq <= q;
    @(posedge aclk);
    preq <= 11'h000;
    repeat (3) @(posedge aclk);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    auto_gating_select = 1'b0;
    foreach (g[i]) g[i] = 32'h0;
  endtask

  // ----------------------------------------------------------------
  // Result monitor: oldest note against each answer
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready) || |done || |fault) begin
      if (exp_q.size() == 0) begin
        chk("extra", 34'h1, 34'h0);
      end else if (|done || |fault) begin
        chk("unit", {fault, done}, exp_q.pop_front());
      end else if (bvalid) begin
        chk("wresp", {32'h0, bresp}, exp_q.pop_front());
      end else begin
        chk("read", {rdata, rresp}, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {slp, dsl, auto_gating_select, awaddr, araddr, wdata, preq} = 0;
    seed = 32'h4;
    strb = 4'hF;
    mismatches = 0;
    checks = 0;
    offs = '{`PCG_OFF_RUN0, `PCG_OFF_RUN1, `PCG_OFF_SLP0,
             `PCG_OFF_SLP1, `PCG_OFF_DSL0, `PCG_OFF_DSL1};
    rst();
    foreach (offs[i]) rd(offs[i], 32'h0);
    chk("enables", en, 11'h000);
    acc(11'h7FF);
    chk("irq", irq, 1'b0);
    rd(`PCG_OFF_INT_STS, 32'h7FF);
    wr(`PCG_OFF_INT_MSK, 32'h7FF, `PCG_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 1'b1);
    wr(`PCG_OFF_INT_STS, 32'h7FF, `PCG_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 1'b0);
    foreach (offs[i]) begin
      msk = (i % 2) ? `PCG_G1_MASK : `PCG_G0_MASK;
      wr(offs[i], 32'hFFFF_FFFF, `PCG_RESP_OKAY);
      rd(offs[i], msk);
      r = xs();
      wr(offs[i], r, `PCG_RESP_OKAY);
      g[i] = r & msk;
      rd(offs[i], g[i]);
    end
    // Every mix of auto gating, sleep and deep sleep
    for (int k = 0; k < 8; k++) begin
      wr(`PCG_OFF_RCC, {31'h0, k[2]}, `PCG_RESP_OKAY);
      auto_gating_select = k[2];
      slp <= k[1];
      dsl <= k[0];
      repeat (3) @(posedge aclk);
      chk("enables", en, exp_en());
      rd(`PCG_OFF_STATE, {14'h0, dsl, slp, 5'h0, exp_en()});
      r = xs();
      acc(r[10:0] | 11'h001);
    end
    // Read-modify-write hands reserved bits back as read
    g[1] = g[1] | 32'h0000_0001;
    wr(`PCG_OFF_RUN1, g[1], `PCG_RESP_OKAY);
    rd(`PCG_OFF_RUN1, g[1]);
    // Only the strobed byte lands; its reserved bits stay zero
    strb <= 4'h2;
    wr(`PCG_OFF_RUN1, 32'hFFFF_FFFF, `PCG_RESP_OKAY);
    strb <= 4'hF;
    g[1] = g[1] | 32'h0000_1000;
    rd(`PCG_OFF_RUN1, g[1]);
    // State word takes writes quietly and keeps showing live state
    wr(`PCG_OFF_STATE, 32'hFFFF_FFFF, `PCG_RESP_OKAY);
    rd(`PCG_OFF_STATE, {14'h0, dsl, slp, 5'h0, exp_en()});
    // Unmapped and misaligned places refuse and change nothing
    wr(12'h108, 32'hFFFF_FFFF, `PCG_RESP_SLVERR);
    wr(12'h102, 32'hFFFF_FFFF, `PCG_RESP_SLVERR);
    rd(`PCG_OFF_RUN0, g[0]);
    rst();
    rd(`PCG_OFF_DSL1, 32'h0);
    chk("enables", en, 11'h000);
    repeat (5) @(posedge aclk);
    chk("pending", exp_q.size(), 34'h0);
    end_sim();
  end
endmodule
